//--- rtl/pll2_ctrl_pkg.sv
// register map, field positions and codes for the second pll control bank
package pll2_ctrl_pkg;
    localparam logic [11:0] ADDR_OUTPUT_DISABLE = 12'ha41;
    localparam logic [11:0] ADDR_USER_MODE = 12'ha42;
    localparam logic [11:0] ADDR_LOOP_RESET = 12'ha43;
    localparam logic [11:0] ADDR_PHASE_STEP = 12'ha44;
    // output disable fields
    localparam int BIT_DRV_B_OFF = 3;
    localparam int BIT_DRV_A_OFF = 2;
    localparam int BIT_CHAN_B_PD = 1;
    localparam int BIT_CHAN_A_PD = 0;
    localparam logic [3:0] MASK_OUTPUT_DISABLE = 4'hf;
    localparam logic [3:0] RESET_OUTPUT_DISABLE = 4'h0;
    // user mode fields
    localparam int REF_MSB = 6;
    localparam int REF_LSB = 5;
    localparam int MODE_MSB = 4;
    localparam int MODE_LSB = 2;
    localparam int BIT_HOLDOVER = 1;
    localparam int BIT_FREE_RUN = 0;
    localparam logic [6:0] MASK_USER_MODE = 7'h7f;
    localparam logic [6:0] RESET_USER_MODE = 7'h00;
    // loop reset fields
    localparam int BIT_RST_FILTER = 2;
    localparam int BIT_RST_HISTORY = 1;
    localparam int BIT_RST_AUTOSYNC = 0;
    localparam logic [2:0] RESET_LOOP_RESET = 3'h0;
    // phase step fields
    localparam int BIT_PHASE_ZERO = 2;
    localparam int BIT_PHASE_DEC = 1;
    localparam int BIT_PHASE_INC = 0;
    typedef enum logic [1:0] {
        REF_A = 2'h0,
        REF_B = 2'h1,
        REF_C = 2'h2,
        REF_D = 2'h3
    } ref_sel_t;
    typedef enum logic [2:0] {
        MODE_AUTO_REVERT = 3'h0,
        MODE_AUTO_NOREVERT = 3'h1,
        MODE_MANUAL_FALLBACK = 3'h2,
        MODE_MANUAL_HOLDOVER = 3'h3,
        MODE_MANUAL_ONLY = 3'h4
    } switch_mode_t;
endpackage

//--- rtl/second_pll_operational_controls.sv
// control register bank for the second pll channel and its digital loop
// Notes on behaviour
// - bit 3 of output disable powers down only output b driver; divider stays synced.
// - bit 2 of output disable powers down only output a driver; sync kept.
// - bit 1 of output disable powers down output b divider and driver.
// - bit 0 of output disable powers down output a divider and driver.
// - bits 6:5 of user mode pick reference a, b, c or d; reset a.
// - bits 4:2 pick switching mode; 000 auto revertive, 001 auto nonrevertive.
// - mode 010 is manual reference with automatic fallback to another reference.
// - mode 011 is manual reference with fallback into holdover.
// - mode 100 is manual without holdover fallback; 101 to 111 unused.
// - user holdover bit 1 keeps the loop in holdover until cleared; resets zero.
// - user free run bit 0 keeps the loop in free run until cleared.
// - loop reset bit 2 clears the loop filter state.
// - loop reset bit 1 resets the tuning word history logic.
// - loop reset bit 0 resets the automatic synchronization logic.
// - phase bit 2 write of one zeroes the phase offset, then self-clears.
// - phase bit 1 write of one steps the offset down once, then self-clears.
// - phase bit 0 write of one steps the offset up once, then self-clears.
`timescale 1ns/1ps
module second_pll_operational_controls #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic second_channel_output_b_driver_off,
    output logic second_channel_output_a_driver_off,
    output logic second_channel_output_b_power_down,
    output logic second_channel_output_a_power_down,
    output logic [1:0] manual_reference,
    output logic [2:0] switching_mode,
    output logic switching_mode_unused,
    output logic force_holdover,
    output logic force_free_run,
    output logic loop_filter_clear,
    output logic tuning_word_history_reset,
    output logic autosync_reset,
    output logic phase_offset_zero,
    output logic phase_offset_decrement,
    output logic phase_offset_increment
);
    // the map is fixed at twelve bits; narrower buses cannot reach it
    if (ADDR_W < 12) begin : g_addr_too_narrow
        $error("ADDR_W must be at least 12");
    end

    logic [3:0] output_disable;
    logic [6:0] user_mode;
    logic [2:0] loop_reset;
    logic [2:0] phase_pulse;

    // address decode; upper address bits must be zero
    wire logic [11:0] addr_lo = reg_addr[11:0];
    wire logic addr_hi_zero = (reg_addr >> 12) == '0;
    wire logic hit_od = addr_hi_zero && addr_lo == pll2_ctrl_pkg::ADDR_OUTPUT_DISABLE;
    wire logic hit_um = addr_hi_zero && addr_lo == pll2_ctrl_pkg::ADDR_USER_MODE;
    wire logic hit_lr = addr_hi_zero && addr_lo == pll2_ctrl_pkg::ADDR_LOOP_RESET;
    wire logic hit_ps = addr_hi_zero && addr_lo == pll2_ctrl_pkg::ADDR_PHASE_STEP;
    wire logic wr = clk_en && reg_write;
    wire logic rd = clk_en && reg_read;

    // read mux; reserved bits and unmapped addresses read zero
    logic [7:0] next_rdata;
    always_comb begin
        if (hit_od) begin
            next_rdata = {4'h0, output_disable};
        end else if (hit_um) begin
            next_rdata = {1'h0, user_mode};
        end else if (hit_lr) begin
            next_rdata = {5'h0, loop_reset};
        end else begin
            next_rdata = 8'h00; // phase bits self-clear so always read zero
        end
    end

    // read data stands from the cycle after the strobe until the next enabled edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= rd ? next_rdata : 8'h00;
        end
    end

    // level registers; written bits above the fields are dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            output_disable <= pll2_ctrl_pkg::RESET_OUTPUT_DISABLE;
            user_mode <= pll2_ctrl_pkg::RESET_USER_MODE;
            loop_reset <= pll2_ctrl_pkg::RESET_LOOP_RESET;
        end else if (wr) begin
            if (hit_od) begin
                output_disable <= reg_wdata[3:0];
            end
            if (hit_um) begin
                user_mode <= reg_wdata[6:0];
            end
            if (hit_lr) begin
                loop_reset <= reg_wdata[2:0];
            end
        end
    end

    // phase commands: one pulse per write, held until the next enabled edge, no stored state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_pulse <= 3'h0;
        end else if (clk_en) begin
            phase_pulse <= (wr && hit_ps) ? reg_wdata[2:0] : 3'h0;
        end
    end

    // output power controls
    assign second_channel_output_b_driver_off = output_disable[pll2_ctrl_pkg::BIT_DRV_B_OFF];
    assign second_channel_output_a_driver_off = output_disable[pll2_ctrl_pkg::BIT_DRV_A_OFF];
    // channel power-down and driver-only disable are independent outputs
    assign second_channel_output_b_power_down = output_disable[pll2_ctrl_pkg::BIT_CHAN_B_PD];
    assign second_channel_output_a_power_down = output_disable[pll2_ctrl_pkg::BIT_CHAN_A_PD];

    // loop mode controls
    assign manual_reference = user_mode[pll2_ctrl_pkg::REF_MSB:pll2_ctrl_pkg::REF_LSB];
    // codes 010 and 011 pass through unchanged for the switch machine
    assign switching_mode = user_mode[pll2_ctrl_pkg::MODE_MSB:pll2_ctrl_pkg::MODE_LSB];
    // unused codes are flagged, not remapped; the switch machine decides
    assign switching_mode_unused = switching_mode > 3'h4;
    assign force_holdover = user_mode[pll2_ctrl_pkg::BIT_HOLDOVER];
    assign force_free_run = user_mode[pll2_ctrl_pkg::BIT_FREE_RUN];

    // debug resets held while the bits are set
    assign loop_filter_clear = loop_reset[pll2_ctrl_pkg::BIT_RST_FILTER];
    assign tuning_word_history_reset = loop_reset[pll2_ctrl_pkg::BIT_RST_HISTORY];
    assign autosync_reset = loop_reset[pll2_ctrl_pkg::BIT_RST_AUTOSYNC];

    assign phase_offset_zero = phase_pulse[pll2_ctrl_pkg::BIT_PHASE_ZERO];
    assign phase_offset_decrement = phase_pulse[pll2_ctrl_pkg::BIT_PHASE_DEC];
    assign phase_offset_increment = phase_pulse[pll2_ctrl_pkg::BIT_PHASE_INC];

    // checks
    sequence s_phase_write(int b);
        clk_en && reg_write && hit_ps && reg_wdata[b];
    endsequence

    chk_drv_b_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_od |=> second_channel_output_b_driver_off == $past(reg_wdata[3]))
        else $error("output b driver disable not taken");
    chk_drv_a_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_od |=> second_channel_output_a_driver_off == $past(reg_wdata[2]))
        else $error("output a driver disable not taken");
    chk_chan_b_pd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_od |=> second_channel_output_b_power_down == $past(reg_wdata[1]))
        else $error("output b power-down not taken");
    chk_chan_a_pd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_od |=> second_channel_output_a_power_down == $past(reg_wdata[0]))
        else $error("output a power-down not taken");
    chk_ref_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_um |=> manual_reference == $past(reg_wdata[6:5]))
        else $error("manual reference not taken");
    chk_mode_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_um |=> switching_mode == $past(reg_wdata[4:2]))
        else $error("switching mode not taken");
    chk_mode_unused: assert property (@(posedge clk_sys) disable iff (!rst_n)
        switching_mode_unused == (switching_mode >= 3'h5))
        else $error("unused mode flag wrong");
    chk_holdover_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        force_holdover && !(wr && hit_um) |=> force_holdover)
        else $error("holdover dropped without a write");
    chk_free_run_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        force_free_run && !(wr && hit_um) |=> force_free_run)
        else $error("free run dropped without a write");
    chk_filter_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_lr |=> loop_filter_clear == $past(reg_wdata[2]))
        else $error("loop filter clear not taken");
    chk_history_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_lr |=> tuning_word_history_reset == $past(reg_wdata[1]))
        else $error("history reset not taken");
    chk_autosync_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr && hit_lr |=> autosync_reset == $past(reg_wdata[0]))
        else $error("autosync reset not taken");
    chk_zero_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_phase_write(2) |=> phase_offset_zero
        ##1 (!phase_offset_zero || $past(wr && hit_ps) || !$past(clk_en)))
        else $error("phase zero pulse wrong");
    chk_dec_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_phase_write(1) |=> phase_offset_decrement
        ##1 (!phase_offset_decrement || $past(wr && hit_ps) || !$past(clk_en)))
        else $error("phase decrement pulse wrong");
    chk_inc_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_phase_write(0) |=> phase_offset_increment
        ##1 (!phase_offset_increment || $past(wr && hit_ps) || !$past(clk_en)))
        else $error("phase increment pulse wrong");
    chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd && (hit_ps || hit_lr) |=> reg_rdata[7:3] == 5'h00)
        else $error("reserved bits read nonzero");
    chk_one_action: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_offset_increment && clk_en |-> $past(wr && hit_ps) || !$past(clk_en))
        else $error("phase action without a write");
endmodule

//--- tb/second_pll_operational_controls_test.sv
// self-checking bench for the second pll control bank
`timescale 1ns/1ps
module second_pll_operational_controls_test;
    logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, e_rd;
    logic drv_b, drv_a, pd_b, pd_a, unused, hold, free, filt, hist, asy, ph_z, ph_d, ph_i;
    logic [1:0] mref;
    logic [2:0] mode, e_lr, e_ph, s_lr;
    logic [3:0] e_od, s_od;
    logic [6:0] e_um, s_um;
    logic [7:0] q[$];
    int fails = 0, total_checks = 0, seed = 32'hc931, r;

    always #10 clk_sys = ~clk_sys;

    second_pll_operational_controls #(.ADDR_W(12)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .second_channel_output_b_driver_off(drv_b), .second_channel_output_a_driver_off(drv_a),
        .second_channel_output_b_power_down(pd_b), .second_channel_output_a_power_down(pd_a),
        .manual_reference(mref), .switching_mode(mode), .switching_mode_unused(unused),
        .force_holdover(hold), .force_free_run(free), .loop_filter_clear(filt),
        .tuning_word_history_reset(hist), .autosync_reset(asy), .phase_offset_zero(ph_z),
        .phase_offset_decrement(ph_d), .phase_offset_increment(ph_i));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // expected read data from the driver's own copy of the registers
    function automatic logic [7:0] rexp(input logic [11:0] a);
        case (a)
            pll2_ctrl_pkg::ADDR_OUTPUT_DISABLE: return {4'h0, s_od};
            pll2_ctrl_pkg::ADDR_USER_MODE: return {1'b0, s_um};
            pll2_ctrl_pkg::ADDR_LOOP_RESET: return {5'h0, s_lr};
            default: return 8'h00; // phase bits self-clear, unmapped reads zero
        endcase
    endfunction

    // one bus cycle; strobes are assigned once per edge so back to back is safe
    task automatic op(input logic en, input logic wr, input logic rd, input logic [11:0] a,
            input logic [7:0] d);
        clk_en <= en;
        reg_write <= wr;
        reg_read <= rd;
        reg_addr <= a;
        reg_wdata <= d;
        if (en && rd) q.push_back(rexp(a));
        if (en && wr && a == pll2_ctrl_pkg::ADDR_OUTPUT_DISABLE) s_od = d[3:0];
        if (en && wr && a == pll2_ctrl_pkg::ADDR_USER_MODE) s_um = d[6:0];
        if (en && wr && a == pll2_ctrl_pkg::ADDR_LOOP_RESET) s_lr = d[2:0];
        @(posedge clk_sys);
    endtask

    // monitor: outputs at each edge against what the previous edge accepted
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {e_od, e_um, e_lr, e_ph, e_rd} <= '0;
        end else begin
            check("out_disable", {4'h0, drv_b, drv_a, pd_b, pd_a}, {4'h0, e_od});
            check("ref", {6'h0, mref}, {6'h0, e_um[6:5]});
            check("mode", {5'h0, mode}, {5'h0, e_um[4:2]});
            check("unused", {7'h0, unused}, {7'h0, e_um[4:2] > 3'h4});
            check("hold_free", {6'h0, hold, free}, {6'h0, e_um[1:0]});
            check("loop_rst", {5'h0, filt, hist, asy}, {5'h0, e_lr});
            check("phase", {5'h0, ph_z, ph_d, ph_i}, {5'h0, e_ph});
            check("rdata", reg_rdata, e_rd);
            if (clk_en) begin
                e_ph <= 3'h0;
                e_rd <= (reg_read && q.size() > 0) ? q.pop_front() : 8'h00;
                if (reg_write && reg_addr == pll2_ctrl_pkg::ADDR_OUTPUT_DISABLE) e_od <= reg_wdata[3:0];
                if (reg_write && reg_addr == pll2_ctrl_pkg::ADDR_USER_MODE) e_um <= reg_wdata[6:0];
                if (reg_write && reg_addr == pll2_ctrl_pkg::ADDR_LOOP_RESET) e_lr <= reg_wdata[2:0];
                if (reg_write && reg_addr == pll2_ctrl_pkg::ADDR_PHASE_STEP) e_ph <= reg_wdata[2:0];
            end
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        report_and_stop();
    end

    initial begin
        {s_od, s_um, s_lr} = '0;
        for (int k = 0; k < 2; k++) begin
            repeat (12) @(posedge clk_sys);
            rst_n <= 1'b1;
            @(posedge clk_sys);
            // reset values, unmapped neighbours included
            for (int i = 0; i < 8; i++) op(1'b1, 1'b0, 1'b1, 12'ha40 + 12'(i), 8'h00);
            // reserved bits ignored, writes to unmapped places change nothing
            for (int i = 0; i < 8; i++) op(1'b1, 1'b1, 1'b0, 12'ha40 + 12'(i), 8'hff);
            for (int i = 0; i < 8; i++) op(1'b1, 1'b0, 1'b1, 12'ha40 + 12'(i), 8'h00);
            // every switching mode and reference code, read back at once
            for (int i = 0; i < 8; i++) begin
                op(1'b1, 1'b1, 1'b0, 12'ha42, {1'b1, 2'(i), 3'(i), 1'(i), ~1'(i)});
                op(1'b1, 1'b0, 1'b1, 12'ha42, 8'h00);
            end
            // loop resets one at a time, then phase commands back to back
            for (int i = 0; i < 4; i++) op(1'b1, 1'b1, 1'b0, 12'ha43, 8'h01 << i);
            for (int i = 0; i < 5; i++) op(1'b1, 1'b1, 1'b0, 12'ha44, 8'h01 << i);
            op(1'b1, 1'b1, 1'b0, 12'ha44, 8'h07);
            op(1'b1, 1'b0, 1'b1, 12'ha44, 8'h00);
            // a write while the enable is low must not land
            op(1'b0, 1'b1, 1'b0, 12'ha41, 8'h05);
            op(1'b1, 1'b0, 1'b1, 12'ha41, 8'h00);
            // random traffic, enable dropped now and then
            repeat (300) begin
                r = $random(seed);
                op(r[7:5] != 3'h0, r[4:3] < 2'h2, r[4:3] == 2'h2, 12'ha40 + 12'(r[2:0]), r[15:8]);
            end
            op(1'b1, 1'b1, 1'b0, 12'ha41, 8'h0f);
            op(1'b1, 1'b1, 1'b0, 12'ha42, 8'h7f);
            op(1'b1, 1'b0, 1'b0, 12'h000, 8'h00);
            // mid-run reset clears the output disable, reference, holdover and free run outputs at once
            rst_n <= 1'b0;
            #1;
            check("reset_out", {drv_b, drv_a, pd_b, pd_a, mref, hold, free}, 8'h00);
            {s_od, s_um, s_lr} = '0;
            q.delete();
        end
        report_and_stop();
    end
endmodule
